//--- rtl/dpl_top.sv
`timescale 1ns/1ns
module dpl_top #(
	parameter int NUM_CH = dpl_pkg::NCH,
	parameter int NUM_OUT = dpl_pkg::NOUT
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [dpl_pkg::NCH-1:0] sensor_i,
	input wire logic [dpl_pkg::NCH-1:0] chan_fault_i,
	input wire logic [dpl_pkg::NOUT-1:0] out_fault_i,
	input wire logic module_fault_i,
	input wire logic [dpl_pkg::NOUT-1:0] dark_req_i,
	input wire dpl_pkg::dpl_cfg_type cfg_i,
	input wire logic ack_i,
	input wire logic reinsert_i,
	input wire logic rx_vld_i,
	input wire dpl_pkg::dpl_rx_type rx_i,
	output logic [dpl_pkg::NCH-1:0] proc_o,
	output logic [dpl_pkg::NCH-1:0] pass_o,
	output logic [dpl_pkg::NOUT-1:0] out_pass_o,
	output logic [dpl_pkg::NP-1:0] disc_err_o,
	output logic [dpl_pkg::NOUT-1:0] high_side_switch_o,
	output logic [dpl_pkg::NOUT-1:0] low_side_switch_o,
	output logic fault_rpt_o,
	output logic crc_err_o,
	output logic tx_vld_o,
	output dpl_pkg::dpl_tx_type tx_o
);
	// ****************************************
	// Elaboration check
	// ****************************************
	// The state record is sized by the package, so other sizes cannot be served.
	if (NUM_CH != dpl_pkg::NCH || NUM_OUT != dpl_pkg::NOUT) begin : g_bad
		$error("dpl_top: channel counts must match the package");
	end

	dpl_pkg::dpl_state_type st_r;
	dpl_pkg::dpl_state_type st_nxt;
	logic rx_ok;

	// Frame check on the incoming safety frame.
	assign rx_ok = dpl_pkg::dpl_crc8(16'({rx_i.sol, rx_i.outs})) == rx_i.crc;

	// ****************************************
	// Next state
	// ****************************************
	// One pass computes every field; faults first, then values, then frames.
	always_comb begin
		logic [dpl_pkg::NCH-1:0] chf;
		logic [dpl_pkg::NP-1:0] mis;
		logic any_cf;
		logic any_of;
		logic mod_f;
		logic reint_ok;
		logic on;
		int p;
		chf = '0;
		mis = '0;
		any_cf = 1'b0;
		any_of = 1'b0;
		mod_f = 1'b0;
		reint_ok = 1'b0;
		on = 1'b0;
		p = 0;
		st_nxt = st_r;

		// Pins cross three stages; a level is taken once stages two and three agree.
		st_nxt.s1 = {module_fault_i, out_fault_i, chan_fault_i, sensor_i};
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int b = 0; b < dpl_pkg::PIN_W; b++) begin
			if (st_r.s2[b] == st_r.s3[b]) begin
				st_nxt.pin[b] = st_r.s3[b];
			end
		end

		// Discrepancy analysis per pair; single pairs never count.
		for (int q = 0; q < dpl_pkg::NP; q++) begin
			if (cfg_i.noneq[q]) begin
				mis[q] = cfg_i.dual[q] & (st_r.pin[2*q] == st_r.pin[2*q+1]);
			end else begin
				mis[q] = cfg_i.dual[q] & (st_r.pin[2*q] != st_r.pin[2*q+1]);
			end
			// Counter saturates at the limit so a long fault cannot wrap it back.
			if (!mis[q]) begin
				st_nxt.dcnt[q] = '0;
			end else if (st_r.dcnt[q] < cfg_i.disc_time) begin
				st_nxt.dcnt[q] = st_r.dcnt[q] + 1'b1;
			end
			st_nxt.derr[q] = mis[q] & (st_nxt.dcnt[q] >= cfg_i.disc_time);
		end

		// Channel faults: wire break or short, plus a discrepancy on the pair.
		for (int c = 0; c < dpl_pkg::NCH; c++) begin
			p = c / 2;
			chf[c] = st_r.pin[dpl_pkg::CF_LSB+c] | st_nxt.derr[p];
		end
		any_cf = |chf;
		any_of = |st_r.pin[dpl_pkg::OF_LSB +: dpl_pkg::NOUT];
		// Without per-channel passivation any fault takes the whole module down.
		mod_f = st_r.pin[dpl_pkg::MF_BIT] | (!cfg_i.per_chan & (any_cf | any_of));

		unique case (cfg_i.reint)
			dpl_pkg::REINT_AUTO: reint_ok = 1'b1;
			dpl_pkg::REINT_ACK: reint_ok = ack_i;
			dpl_pkg::REINT_REINSERT: reint_ok = reinsert_i;
			default: reint_ok = 1'b0;
		endcase

		// A standing fault always wins over a release in the same cycle.
		for (int c = 0; c < dpl_pkg::NCH; c++) begin
			p = c / 2;
			if (chf[c] | mod_f) begin
				st_nxt.pass[c] = 1'b1;
			end else if (reint_ok) begin
				st_nxt.pass[c] = 1'b0;
			end
			// A dual pair reports one sensor function, taken from its first channel.
			if (st_nxt.pass[c]) begin
				st_nxt.proc[c] = 1'b0;
			end else if (cfg_i.dual[p]) begin
				st_nxt.proc[c] = st_r.pin[2*p];
			end else begin
				st_nxt.proc[c] = st_r.pin[dpl_pkg::SENS_LSB+c];
			end
		end

		// Accepted frames update the commanded outputs.
		if (rx_vld_i && rx_ok) begin
			st_nxt.ocmd = rx_i.outs;
		end

		// Outputs: fail-safe zero when passivated, dark periods on request.
		for (int j = 0; j < dpl_pkg::NOUT; j++) begin
			if (st_r.pin[dpl_pkg::OF_LSB+j] | mod_f) begin
				st_nxt.opass[j] = 1'b1;
			end else if (reint_ok) begin
				st_nxt.opass[j] = 1'b0;
			end
			on = st_nxt.ocmd[j] & !st_nxt.opass[j];
			// A dark period is only inserted while the output is really on.
			if (st_r.dark[j] != '0) begin
				st_nxt.dark[j] = st_r.dark[j] - 1'b1;
			end else if (dark_req_i[j] && st_r.hs[j] && on) begin
				st_nxt.dark[j] = dpl_pkg::DARK_LOAD;
			end
			st_nxt.hs[j] = on & (st_nxt.dark[j] == '0);
			st_nxt.ls[j] = on & (st_nxt.dark[j] == '0);
		end

		// Answer frame echoes the sign of life one cycle after a good frame.
		st_nxt.tx_vld = rx_vld_i & rx_ok;
		st_nxt.crc_err = rx_vld_i & !rx_ok;
		if (rx_vld_i && rx_ok) begin
			st_nxt.tx.sol = rx_i.sol;
			st_nxt.tx.vals = st_nxt.proc;
			st_nxt.tx.crc = dpl_pkg::dpl_crc8({rx_i.sol, st_nxt.proc});
		end

		// Report pulse on every new passivation and every bad frame.
		st_nxt.rpt = (|(st_nxt.pass & ~st_r.pass)) | (|(st_nxt.opass & ~st_r.opass))
			| st_nxt.crc_err;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign proc_o = st_r.proc;
	assign pass_o = st_r.pass;
	assign out_pass_o = st_r.opass;
	assign disc_err_o = st_r.derr;
	assign high_side_switch_o = st_r.hs;
	assign low_side_switch_o = st_r.ls;
	assign fault_rpt_o = st_r.rpt;
	assign crc_err_o = st_r.crc_err;
	assign tx_vld_o = st_r.tx_vld;
	assign tx_o = st_r.tx;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	property p_single;
		!$past(cfg_i.dual[0]) && !pass_o[0] |-> proc_o[0] == $past(st_r.pin[0]);
	endproperty
	a_single: assert property (p_single) else $error("single value wrong");

	property p_count;
		cfg_i.dual[0] && !cfg_i.noneq[0] && st_r.pin[0] != st_r.pin[1]
			&& st_r.dcnt[0] < cfg_i.disc_time |=> st_r.dcnt[0] == $past(st_r.dcnt[0]) + 1'b1;
	endproperty
	a_count: assert property (p_count) else $error("discrepancy count stalled");

	property p_clear;
		cfg_i.dual[0] && !cfg_i.noneq[0] && st_r.pin[0] == st_r.pin[1] |=> st_r.dcnt[0] == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("discrepancy count kept");

	property p_derr;
		disc_err_o[0] |-> $past(cfg_i.dual[0]) && st_r.dcnt[0] >= $past(cfg_i.disc_time);
	endproperty
	a_derr: assert property (p_derr) else $error("discrepancy error early");

	property p_derr_pass;
		disc_err_o[0] |-> pass_o[0] && pass_o[1];
	endproperty
	a_derr_pass: assert property (p_derr_pass) else $error("pair not passivated");

	property p_module;
		st_r.pin[dpl_pkg::MF_BIT] |=> (&pass_o) && (&out_pass_o);
	endproperty
	a_module: assert property (p_module) else $error("module fault not passivating");

	property p_safe_in;
		pass_o[0] |-> !proc_o[0] && (!tx_o.vals[0] || !tx_vld_o);
	endproperty
	a_safe_in: assert property (p_safe_in) else $error("live value while passivated");

	property p_safe_out;
		out_pass_o[0] |-> !high_side_switch_o[0] && !low_side_switch_o[0];
	endproperty
	a_safe_out: assert property (p_safe_out) else $error("output on while passivated");

	property p_pair_sw;
		high_side_switch_o == low_side_switch_o;
	endproperty
	a_pair_sw: assert property (p_pair_sw) else $error("switches disagree");

	sequence s_dark_go;
		dark_req_i[3] && high_side_switch_o[3] && st_r.dark[3] == '0
			&& st_nxt.ocmd[3] && !st_nxt.opass[3];
	endsequence
	property p_dark;
		s_dark_go |=> !high_side_switch_o[3] [*8];
	endproperty
	a_dark: assert property (p_dark) else $error("dark period too short");

	property p_bad_frame;
		rx_vld_i && !rx_ok |=> crc_err_o && fault_rpt_o && !tx_vld_o;
	endproperty
	a_bad_frame: assert property (p_bad_frame) else $error("bad frame accepted");

	sequence s_good_frame;
		rx_vld_i && rx_ok;
	endsequence
	property p_sol;
		s_good_frame |=> tx_vld_o && tx_o.sol == $past(rx_i.sol);
	endproperty
	a_sol: assert property (p_sol) else $error("sign of life not echoed");

	property p_report;
		|(pass_o & ~$past(pass_o)) |-> fault_rpt_o;
	endproperty
	a_report: assert property (p_report) else $error("fault not reported");

	property p_hold;
		pass_o[0] && cfg_i.reint == dpl_pkg::REINT_REINSERT && !reinsert_i |=> pass_o[0];
	endproperty
	a_hold: assert property (p_hold) else $error("early reintegration");

	property p_ack;
		pass_o[0] && cfg_i.reint == dpl_pkg::REINT_ACK && !ack_i |=> pass_o[0];
	endproperty
	a_ack: assert property (p_ack) else $error("reintegration without ack");

	// Further guards on pairing, module-wide passivation and release per channel.
	property p_noneq;
		cfg_i.dual[1] && cfg_i.noneq[1] && st_r.pin[2] == st_r.pin[3]
			&& st_r.dcnt[1] < cfg_i.disc_time |=> st_r.dcnt[1] == $past(st_r.dcnt[1]) + 1'b1;
	endproperty
	a_noneq: assert property (p_noneq) else $error("non-equivalence count stalled");

	property p_dual_val;
		$past(cfg_i.dual[0]) && !pass_o[1] |-> proc_o[1] == $past(st_r.pin[0]);
	endproperty
	a_dual_val: assert property (p_dual_val) else $error("pair value not shared");

	property p_whole;
		!cfg_i.per_chan && (|st_r.pin[dpl_pkg::CF_LSB +: dpl_pkg::NCH])
			|=> (&pass_o) && (&out_pass_o);
	endproperty
	a_whole: assert property (p_whole) else $error("module not passivated");

	property p_chan_only;
		cfg_i.per_chan && cfg_i.reint == dpl_pkg::REINT_AUTO && !st_r.pin[dpl_pkg::MF_BIT]
			&& !cfg_i.dual[2] && !st_r.pin[dpl_pkg::CF_LSB+5] |=> !pass_o[5];
	endproperty
	a_chan_only: assert property (p_chan_only) else $error("healthy channel held");

	property p_reint_auto;
		pass_o[4] && cfg_i.per_chan && cfg_i.reint == dpl_pkg::REINT_AUTO
			&& !st_r.pin[dpl_pkg::MF_BIT] && !cfg_i.dual[2] && !st_r.pin[dpl_pkg::CF_LSB+4]
			|=> !pass_o[4];
	endproperty
	a_reint_auto: assert property (p_reint_auto) else $error("no auto release");
endmodule // dpl_top

//--- rtl/dpl_pkg.sv
// What this block does
// - Single mode: one channel per sensor, its value used directly.
// - Dual mode: two channels per sensor compared for equivalence or non-equivalence.
// - Check starts on mismatch (equivalent) or match (non-equivalent).
// - Relation still wrong after discrepancy time: flag discrepancy error for the pair.
// - Discrepancy time is configurable, one disc_time shared by every dual pair.
// - A fault passivates the affected channel or all channels.
// - Every new passivation and every bad frame is reported on fault_rpt_o.
// - Passivated output is driven zero instead of the commanded value.
// - Passivated input delivers substitute zero instead of the live value.
// - Per-channel mode: channel fault passivates its channel, module fault all.
// - Cleared channel fault: reintegrate automatically or stay until reinsertion.
// - Each output uses high-side and low-side switch driven together.
// - Active output may get brief test dark periods.
// - Frames carry a CRC, checked before acceptance.
// - Host sign of life is acknowledged within the acknowledgement time.
// - Reintegration happens automatically or after program acknowledgement.
package dpl_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int NCH = 8;
	localparam int NP = NCH / 2;
	localparam int NOUT = 4;
	localparam int DCNT_W = 16;
	localparam int DARK_W = 8;
	// Pin vector layout after synchronisation.
	localparam int SENS_LSB = 0;
	localparam int CF_LSB = NCH;
	localparam int OF_LSB = 2 * NCH;
	localparam int MF_BIT = 2 * NCH + NOUT;
	localparam int PIN_W = MF_BIT + 1;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 10;
	localparam int DARK_NS = 1000;
	localparam int DARK_CYC = (DARK_NS / CLK_NS < 1) ? 1 : DARK_NS / CLK_NS;
	localparam logic [DARK_W-1:0] DARK_LOAD = DARK_W'(DARK_CYC);
	// ****************************************
	// Frame check
	// ****************************************
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	typedef enum logic [1:0] {REINT_AUTO, REINT_ACK, REINT_REINSERT} dpl_reint_type;
	typedef struct packed {
		logic [NP-1:0] dual;
		logic [NP-1:0] noneq;
		logic per_chan;
		dpl_reint_type reint;
		logic [DCNT_W-1:0] disc_time;
	} dpl_cfg_type;
	typedef struct packed {
		logic [7:0] sol;
		logic [NOUT-1:0] outs;
		logic [7:0] crc;
	} dpl_rx_type;
	typedef struct packed {
		logic [7:0] sol;
		logic [NCH-1:0] vals;
		logic [7:0] crc;
	} dpl_tx_type;
	typedef struct packed {
		logic [PIN_W-1:0] s1;
		logic [PIN_W-1:0] s2;
		logic [PIN_W-1:0] s3;
		logic [PIN_W-1:0] pin;
		logic [NP-1:0][DCNT_W-1:0] dcnt;
		logic [NP-1:0] derr;
		logic [NCH-1:0] pass;
		logic [NOUT-1:0] opass;
		logic [NOUT-1:0] ocmd;
		logic [NOUT-1:0][DARK_W-1:0] dark;
		logic [NCH-1:0] proc;
		logic [NOUT-1:0] hs;
		logic [NOUT-1:0] ls;
		logic rpt;
		logic crc_err;
		logic tx_vld;
		dpl_tx_type tx;
	} dpl_state_type;
	// Serial CRC-8, most significant bit first.
	function automatic logic [7:0] dpl_crc8(input logic [15:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction
endpackage

//--- tb/dpl_host.sv
`timescale 1ns/1ns
// ****************************************
// Safety host model
// ****************************************
module dpl_host (
	input wire logic mclk_i,
	input wire logic go_i,
	input wire logic bad_i,
	input wire logic [dpl_pkg::NOUT-1:0] outs_i,
	output logic rx_vld_o,
	output dpl_pkg::dpl_rx_type rx_o,
	output logic [7:0] sol_o
);
	// The host keeps its own CRC so that a slip shared with the design cannot hide.
	function automatic logic [7:0] host_crc(input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction
	initial begin
		rx_vld_o = 1'b0;
		rx_o = '0;
		sol_o = 8'h00;
	end
	// One frame per request; outside frames the data lines toggle so stale values cannot match.
	always @(posedge mclk_i) begin
		rx_vld_o <= #1 go_i;
		if (go_i) begin
			sol_o <= #1 sol_o + 8'h01;
			rx_o <= #1 {sol_o + 8'h01, outs_i,
				host_crc({4'h0, sol_o + 8'h01, outs_i}) ^ {7'h00, bad_i}};
		end else begin
			rx_o <= #1 ~rx_o;
		end
	end
endmodule // dpl_host

//--- tb/dpl_top_tb.sv
`timescale 1ns/1ns
module dpl_top_tb;
	// ****************************************
	// Stimulus and wiring
	// ****************************************
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] sensor_i = '0;
	logic [7:0] chan_fault_i = '0;
	logic [3:0] out_fault_i = '0;
	logic module_fault_i = 1'b0;
	logic [3:0] dark_req_i = '0;
	dpl_pkg::dpl_cfg_type cfg_i = '0;
	logic ack_i = 1'b0;
	logic reinsert_i = 1'b0;
	logic go = 1'b0;
	logic bad = 1'b0;
	logic [3:0] outs = '0;
	logic rx_vld;
	dpl_pkg::dpl_rx_type rx;
	logic [7:0] sol;
	logic [7:0] proc_o;
	logic [7:0] pass_o;
	logic [3:0] out_pass_o;
	logic [3:0] disc_err_o;
	logic [3:0] hs_o;
	logic [3:0] ls_o;
	logic fault_rpt_o;
	logic crc_err_o;
	logic tx_vld_o;
	dpl_pkg::dpl_tx_type tx_o;
	int err_total = 0;
	int num_checks = 0;
	int seed = 32'hC5BD724C;
	int n_rpt = 0;
	int r0;
	always #5 mclk_i = ~mclk_i;
	dpl_host i_host (.mclk_i(mclk_i), .go_i(go), .bad_i(bad), .outs_i(outs),
		.rx_vld_o(rx_vld), .rx_o(rx), .sol_o(sol));
	dpl_top i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .sensor_i(sensor_i),
		.chan_fault_i(chan_fault_i), .out_fault_i(out_fault_i),
		.module_fault_i(module_fault_i), .dark_req_i(dark_req_i), .cfg_i(cfg_i),
		.ack_i(ack_i), .reinsert_i(reinsert_i), .rx_vld_i(rx_vld), .rx_i(rx),
		.proc_o(proc_o), .pass_o(pass_o), .out_pass_o(out_pass_o),
		.disc_err_o(disc_err_o), .high_side_switch_o(hs_o), .low_side_switch_o(ls_o),
		.fault_rpt_o(fault_rpt_o), .crc_err_o(crc_err_o), .tx_vld_o(tx_vld_o), .tx_o(tx_o));
	// Fault reports are single-cycle pulses, so they are counted at every edge.
	always @(posedge mclk_i) begin
		if (fault_rpt_o === 1'b1) n_rpt++;
	end
	// ****************************************
	// Model and checks
	// ****************************************
	// Dual pairs carry the even channel in both slots; passivated slots read zero.
	function automatic logic [7:0] model_proc(input logic [7:0] s, input logic [3:0] d,
		input logic [7:0] p);
		logic [7:0] v;
		for (int q = 0; q < 4; q++) begin
			v[2*q] = s[2*q];
			v[2*q+1] = d[q] ? s[2*q] : s[2*q+1];
		end
		return v & ~p;
	endfunction
	// Reference CRC-8 of the answer frame, kept apart from the design's own function.
	function automatic logic [7:0] model_crc(input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_in(input logic [7:0] p);
		chk("pass", {24'h0, p}, {24'h0, pass_o});
		chk("proc", {24'h0, model_proc(sensor_i, cfg_i.dual, p)}, {24'h0, proc_o});
	endtask
	task automatic chk_sw(input logic [3:0] e);
		chk("high_side", {28'h0, e}, {28'h0, hs_o});
		chk("low_side", {28'h0, e}, {28'h0, ls_o});
	endtask
	task automatic pulse_ack(input logic a, input logic r);
		ack_i = a;
		reinsert_i = r;
		tick(1);
		ack_i = 1'b0;
		reinsert_i = 1'b0;
		tick(3);
	endtask
	// Fault set, fault cleared, then an ack pulse and a reinsert pulse, checking which one releases under the chosen policy.
	task automatic chan_cycle(input logic [7:0] f, input dpl_pkg::dpl_reint_type m);
		cfg_i.reint = m;
		r0 = n_rpt;
		chan_fault_i = f;
		tick(8);
		chk_in(f);
		chk("rpt", 32'h1, {31'h0, n_rpt > r0});
		chan_fault_i = '0;
		tick(8);
		chk_in(m == dpl_pkg::REINT_AUTO ? 8'h00 : f);
		pulse_ack(1'b1, 1'b0);
		chk_in(m == dpl_pkg::REINT_REINSERT ? f : 8'h00);
		pulse_ack(1'b0, 1'b1);
		chk_in(8'h00);
	endtask
	task automatic frame(input logic [3:0] o, input logic b);
		outs = o;
		bad = b;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		tick(1);
		chk("tx_vld", {31'h0, !b}, {31'h0, tx_vld_o});
		chk("crc_err", {31'h0, b}, {31'h0, crc_err_o});
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ****************************************
	// Test sequence
	// ****************************************
	// The watchdog span of 10000 cycles is many times the few hundred cycles the tests need.
	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end
	initial begin
		tick(10);
		chk_in(8'h00);
		chk_sw(4'h0);
		reset_i = 1'b0;
		for (int i = 0; i < 4; i++) begin
			sensor_i = 8'($random(seed));
			tick(8);
			chk_in(8'h00);
		end
		$display("test single done");
		cfg_i.dual = 4'h3;
		cfg_i.noneq = 4'h2;
		cfg_i.disc_time = 16'h001E;
		cfg_i.per_chan = 1'b1;
		sensor_i = 8'h05;
		tick(10);
		chk("disc_err", 32'h0, {28'h0, disc_err_o});
		tick(40);
		chk("disc_err", 32'h1, {28'h0, disc_err_o});
		chk_in(8'h03);
		sensor_i = 8'h0F;
		tick(8);
		chk("disc_err", 32'h0, {28'h0, disc_err_o});
		tick(40);
		chk("disc_err", 32'h2, {28'h0, disc_err_o});
		chk_in(8'h0C);
		sensor_i = 8'h07;
		tick(8);
		chk_in(8'h00);
		cfg_i.dual = 4'h0;
		$display("test discrepancy done");
		cfg_i.per_chan = 1'b1;
		chan_cycle(8'h10, dpl_pkg::REINT_AUTO);
		chan_cycle(8'h21, dpl_pkg::REINT_ACK);
		chan_cycle(8'h41, dpl_pkg::REINT_REINSERT);
		cfg_i.reint = dpl_pkg::REINT_AUTO;
		module_fault_i = 1'b1;
		tick(8);
		chk_in(8'hFF);
		chk("out_pass", 32'hF, {28'h0, out_pass_o});
		module_fault_i = 1'b0;
		cfg_i.per_chan = 1'b0;
		chan_fault_i = 8'h01;
		tick(8);
		chk_in(8'hFF);
		chan_fault_i = 8'h00;
		cfg_i.per_chan = 1'b1;
		tick(8);
		$display("test passivation done");
		frame(4'hA, 1'b0);
		chk("sol", {24'h0, sol}, {24'h0, tx_o.sol});
		chk("vals", {24'h0, model_proc(sensor_i, cfg_i.dual, 8'h00)}, {24'h0, tx_o.vals});
		chk("crc", {24'h0, model_crc({sol, model_proc(sensor_i, cfg_i.dual, 8'h00)})},
			{24'h0, tx_o.crc});
		chk_sw(4'hA);
		frame(4'h5, 1'b1);
		chk_sw(4'hA);
		out_fault_i = 4'h2;
		tick(8);
		chk("out_pass", 32'h2, {28'h0, out_pass_o});
		chk_sw(4'h8);
		out_fault_i = 4'h0;
		tick(8);
		chk_sw(4'hA);
		dark_req_i = 4'h8;
		tick(1);
		dark_req_i = 4'h0;
		tick(50);
		chk_sw(4'h2);
		tick(60);
		chk_sw(4'hA);
		$display("test outputs done");
		report_and_stop();
	end
endmodule // dpl_top_tb
